// ===== logic/ptrs_pkg.sv
// Shared constants and types for the transceiver reset sequencer and its channel model.
package ptrs_pkg;

	// Clock rate and timing figures; the hold and lock-to-data counts are derived from their times.
	localparam int CLK_MHZ       = 200;
	localparam int PLL_HOLD_NS   = 1000;
	localparam int PLL_HOLD_CYC  = (PLL_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int LTD_MANUAL_NS = 4000;
	localparam int LTD_CYC_DEF   = (LTD_MANUAL_NS * CLK_MHZ + 999) / 1000;
	localparam int RX_SETTLE_CYC = 2;
	localparam int RX_PULSE_CYC  = 2;
	localparam int BUSY_SIM_CYC  = 20;
	localparam int PLL_LOCK_DEF  = 100;
	localparam int CDR_LOCK_DEF  = 200;
	localparam int LANES_DEF     = 4;
	localparam int CNT_W         = 16;

	// Register map of the sequencer, one aligned word each.
	localparam int          AXI_AW   = 8;
	localparam logic [7:0]  CTRL_OFS = 8'h00;
	localparam logic [7:0]  STAT_OFS = 8'h04;

	// Control word fields.
	localparam int          CTRL_RESTART  = 0;
	localparam int          CTRL_PD_EN    = 1;
	localparam int          CTRL_FAST     = 2;
	localparam int          CTRL_NORMAL   = 3;
	localparam int          CTRL_LANE_LSB = 4;
	localparam logic [7:0]  CTRL_RST      = 8'h10;

	// Status word fields.
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_PLL_LOCK  = 3;
	localparam int STAT_BUSY      = 4;
	localparam int STAT_PWRDN     = 5;
	localparam int STAT_TX_RST    = 6;
	localparam int STAT_RXFE_RST  = 7;
	localparam int STAT_RXLG_RST  = 8;
	localparam int STAT_PLL_HOLD  = 9;
	localparam int STAT_LOCK_LSB  = 12;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sequencer states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		S_PLL_HOLD  = 3'h0,
		S_WAIT_LOCK = 3'h1,
		S_WAIT_BUSY = 3'h3,
		S_RX_SETTLE = 3'h2,
		S_RUN       = 3'h6,
		S_RELOCK    = 3'h7,
		S_LTD_WAIT  = 3'h5,
		S_RX_PULSE  = 3'h4
	} ptrs_state_t;

endpackage

// ===== logic/ptrs_if.sv
// Interface joining the reset sequencer to the transceiver channel.
`timescale 1ns/10ps
interface ptrs_if #(
	parameter int LANES = ptrs_pkg::LANES_DEF
);
	logic             multipurpose_pll_hold;
	logic             tx_logic_rst;
	logic             rx_frontend_rst;
	logic             rx_logic_rst;
	logic             powerdown;
	logic             pll_lock_flag;
	logic             busy;
	logic [LANES-1:0] rx_lock_to_data;

	// Sequencer end drives resets and power-down.
	modport ctrl_mp (
		output multipurpose_pll_hold,
		output tx_logic_rst,
		output rx_frontend_rst,
		output rx_logic_rst,
		output powerdown,
		input  pll_lock_flag,
		input  busy,
		input  rx_lock_to_data
	);

	// Channel end reports lock and calibration status.
	modport xcvr_mp (
		input  multipurpose_pll_hold,
		input  tx_logic_rst,
		input  rx_frontend_rst,
		input  rx_logic_rst,
		input  powerdown,
		output pll_lock_flag,
		output busy,
		output rx_lock_to_data
	);
endinterface // ptrs_if

// ===== logic/ptrs_xcvr.sv
// Transceiver channel end: PLL, offset cancellation, CDR lock and PHY-done status.
`timescale 1ns/10ps
module ptrs_xcvr
	import ptrs_pkg::*;
#(
	parameter int LANES        = LANES_DEF,
	parameter int PLL_LOCK_CYC = PLL_LOCK_DEF,
	parameter int CDR_LOCK_CYC = CDR_LOCK_DEF,
	parameter int BUSY_CYC     = BUSY_SIM_CYC
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	ptrs_if.xcvr_mp               link,
	input  wire logic             reconfig_access,
	input  wire logic [LANES-1:0] rx_signal_ok,
	output logic                  phy_done_status
);

	logic [CNT_W-1:0] pll_cnt_q;
	logic [CNT_W-1:0] busy_cnt_q;
	logic             cal_done_q;
	logic             rx_logic_prev_q;
	logic             pll_stop;
	logic             lock_set;

	// The PLL stops whenever it is held or the channel is powered down.
	assign pll_stop = link.multipurpose_pll_hold | link.powerdown;
	assign lock_set = !pll_stop && !link.pll_lock_flag && (pll_cnt_q == CNT_W'(PLL_LOCK_CYC - 1));

	// PLL acquires lock a fixed time after its hold is released.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pll_cnt_q          <= '0;
			link.pll_lock_flag <= 1'b0;
		end else if (pll_stop) begin
			pll_cnt_q          <= '0;
			link.pll_lock_flag <= 1'b0;
		end else if (lock_set) begin
			link.pll_lock_flag <= 1'b1;
		end else if (!link.pll_lock_flag) begin
			pll_cnt_q <= pll_cnt_q + CNT_W'(1);
		end
	end

	// Offset cancellation runs after the first lock following reset or power-down, otherwise only for a reconfiguration access.
	// On a lock that starts calibration, busy rises on the same edge, so the sequencer does not see that lock without it.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link.busy  <= 1'b0;
			busy_cnt_q <= '0;
			cal_done_q <= 1'b0;
		end else if (link.powerdown) begin
			link.busy  <= 1'b0;
			busy_cnt_q <= '0;
			cal_done_q <= 1'b0;
		end else if (link.busy) begin
			if (busy_cnt_q == CNT_W'(BUSY_CYC - 1)) begin
				link.busy <= 1'b0;
			end else begin
				busy_cnt_q <= busy_cnt_q + CNT_W'(1);
			end
		end else if (lock_set && !cal_done_q) begin
			link.busy  <= 1'b1;
			busy_cnt_q <= '0;
			cal_done_q <= 1'b1;
		end else if (reconfig_access && cal_done_q) begin
			link.busy  <= 1'b1;
			busy_cnt_q <= '0;
		end
	end

	// Each lane's CDR locks to data a fixed time after its front end leaves reset.
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [CNT_W-1:0] cdr_cnt_q;
			logic [1:0]       sig_sync_q;

			// Signal detect comes from the analogue side, so it passes two flops before use.
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sig_sync_q <= 2'h0;
				end else begin
					sig_sync_q <= {sig_sync_q[0], rx_signal_ok[g]};
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					cdr_cnt_q               <= '0;
					link.rx_lock_to_data[g] <= 1'b0;
				end else if (link.rx_frontend_rst || link.powerdown || !sig_sync_q[1]) begin
					cdr_cnt_q               <= '0;
					link.rx_lock_to_data[g] <= 1'b0;
				end else if (cdr_cnt_q == CNT_W'(CDR_LOCK_CYC - 1)) begin
					link.rx_lock_to_data[g] <= 1'b1;
				end else begin
					cdr_cnt_q <= cdr_cnt_q + CNT_W'(1);
				end
			end
		end
	endgenerate

	// A one-cycle PHY-done pulse follows each release of the receiver logic reset.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_logic_prev_q <= 1'b1;
			phy_done_status <= 1'b0;
		end else begin
			rx_logic_prev_q <= link.rx_logic_rst;
			phy_done_status <= rx_logic_prev_q && !link.rx_logic_rst;
		end
	end

endmodule // ptrs_xcvr

// ===== logic/ptrs_ctrl.sv
// Reset sequencer for a PCIe transceiver channel with an AXI4-Lite control port.
`timescale 1ns/10ps
module ptrs_ctrl
	import ptrs_pkg::*;
#(
	parameter int LANES   = LANES_DEF,
	parameter int LTD_CYC = LTD_CYC_DEF
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	ptrs_if.ctrl_mp                link,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	ptrs_state_t      state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [7:0]       ctrl_q;
	logic             restart_q;
	logic             aw_hold_q;
	logic             w_hold_q;
	logic [AXI_AW-1:0] awaddr_q;
	logic [31:0]      wdata_q;
	logic [3:0]       wstrb_q;
	logic             aw_ok;
	logic             w_ok;
	logic             b_done;
	logic             wr_go;
	logic             aw_hold_d;
	logic             w_hold_d;
	logic             rvalid_d;
	logic             all_locked;
	logic [LANES-1:0] lane_mask;
	logic             pd_en;
	logic [31:0]      stat_word;

	assign pd_en     = ctrl_q[CTRL_PD_EN];
	assign lane_mask = ctrl_q[CTRL_LANE_LSB +: LANES];

	// Lanes left out of the bond count as locked so x1, x2 and x4 share one test.
	assign all_locked = &(link.rx_lock_to_data | ~lane_mask);

	// Write channel handshakes; address and data may arrive in either order.
	assign aw_ok     = s_axi_awvalid && s_axi_awready;
	assign w_ok      = s_axi_wvalid && s_axi_wready;
	assign b_done    = s_axi_bvalid && s_axi_bready;
	assign wr_go     = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign aw_hold_d = (aw_hold_q || aw_ok) && !b_done;
	assign w_hold_d  = (w_hold_q || w_ok) && !b_done;
	assign rvalid_d  = (s_axi_rvalid && !s_axi_rready) || (s_axi_arvalid && s_axi_arready);

	// Main sequence; a software restart re-enters the PLL hold step.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_PLL_HOLD;
			cnt_q   <= '0;
		end else if (restart_q) begin
			state_q <= S_PLL_HOLD;
			cnt_q   <= '0;
		end else begin
			case (state_q)
				S_PLL_HOLD: begin
					// In power-down mode the hold stretches while busy, keeping power-down off it.
					if (!(pd_en && link.busy)) begin
						if (cnt_q == CNT_W'(PLL_HOLD_CYC - 1)) begin
							state_q <= S_WAIT_LOCK;
							cnt_q   <= '0;
						end else begin
							cnt_q <= cnt_q + CNT_W'(1);
						end
					end
				end
				S_WAIT_LOCK: begin
					if (link.pll_lock_flag) begin
						state_q <= S_WAIT_BUSY;
					end
				end
				S_WAIT_BUSY: begin
					if (!link.busy) begin
						state_q <= S_RX_SETTLE;
						cnt_q   <= '0;
					end
				end
				S_RX_SETTLE: begin
					if (cnt_q == CNT_W'(RX_SETTLE_CYC - 1)) begin
						state_q <= S_RUN;
					end else begin
						cnt_q <= cnt_q + CNT_W'(1);
					end
				end
				S_RUN: begin
					// Lock-to-data is ignored until software declares the normal phase.
					if (ctrl_q[CTRL_NORMAL] && !all_locked) begin
						state_q <= S_RELOCK;
					end
				end
				S_RELOCK: begin
					if (all_locked) begin
						state_q <= ctrl_q[CTRL_FAST] ? S_RX_PULSE : S_LTD_WAIT;
						cnt_q   <= '0;
					end
				end
				S_LTD_WAIT: begin
					if (!all_locked) begin
						state_q <= S_RELOCK;
					end else if (cnt_q == CNT_W'(LTD_CYC - 1)) begin
						state_q <= S_RX_PULSE;
						cnt_q   <= '0;
					end else begin
						cnt_q <= cnt_q + CNT_W'(1);
					end
				end
				S_RX_PULSE: begin
					if (cnt_q == CNT_W'(RX_PULSE_CYC - 1)) begin
						state_q <= S_RUN;
					end else begin
						cnt_q <= cnt_q + CNT_W'(1);
					end
				end
				default: begin
					state_q <= S_PLL_HOLD;
					cnt_q   <= '0;
				end
			endcase
		end
	end

	// Reset outputs follow the state one cycle later; out of reset the hold and resets are asserted and power-down is off.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link.multipurpose_pll_hold <= 1'b1;
			link.tx_logic_rst          <= 1'b1;
			link.rx_frontend_rst       <= 1'b1;
			link.rx_logic_rst          <= 1'b1;
			link.powerdown             <= 1'b0;
		end else begin
			link.multipurpose_pll_hold <= (state_q == S_PLL_HOLD);
			link.tx_logic_rst          <= (state_q == S_PLL_HOLD) || (state_q == S_WAIT_LOCK);
			link.rx_frontend_rst       <= (state_q == S_PLL_HOLD) || (state_q == S_WAIT_LOCK) ||
			                              (state_q == S_WAIT_BUSY) || (state_q == S_RX_SETTLE);
			link.rx_logic_rst          <= (state_q == S_PLL_HOLD) || (state_q == S_WAIT_LOCK) ||
			                              (state_q == S_WAIT_BUSY) || (state_q == S_RX_SETTLE) ||
			                              (state_q == S_RX_PULSE);
			link.powerdown             <= pd_en && (state_q == S_PLL_HOLD) && !link.busy;
		end
	end

	// Write address and data capture, held until the response is taken.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			aw_hold_q     <= aw_hold_d;
			w_hold_q      <= w_hold_d;
			s_axi_awready <= !aw_hold_d;
			s_axi_wready  <= !w_hold_d;
			if (aw_ok) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_ok) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// Register update and write response; writes to status are ignored, others refused.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q       <= CTRL_RST;
			restart_q    <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			restart_q <= 1'b0;
			if (b_done) begin
				s_axi_bvalid <= 1'b0;
			end else if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				if (awaddr_q[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2]) begin
					if (wstrb_q[0]) begin
						ctrl_q    <= {wdata_q[7:1], 1'b0};
						restart_q <= wdata_q[CTRL_RESTART];
					end
				end else if (awaddr_q[AXI_AW-1:2] != STAT_OFS[AXI_AW-1:2]) begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end
		end
	end

	// Status word showing the sequence state and the channel flags.
	always_comb begin
		stat_word                                  = '0;
		stat_word[STAT_STATE_LSB +: 3]             = state_q;
		stat_word[STAT_PLL_LOCK]                   = link.pll_lock_flag;
		stat_word[STAT_BUSY]                       = link.busy;
		stat_word[STAT_PWRDN]                      = link.powerdown;
		stat_word[STAT_TX_RST]                     = link.tx_logic_rst;
		stat_word[STAT_RXFE_RST]                   = link.rx_frontend_rst;
		stat_word[STAT_RXLG_RST]                   = link.rx_logic_rst;
		stat_word[STAT_PLL_HOLD]                   = link.multipurpose_pll_hold;
		stat_word[STAT_LOCK_LSB +: LANES]          = link.rx_lock_to_data;
	end

	// Read channel: data is captured on the address edge and answered the next cycle.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_rvalid  <= rvalid_d;
			s_axi_arready <= !rvalid_d;
			if (s_axi_arvalid && s_axi_arready) begin
				if (s_axi_araddr[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2]) begin
					s_axi_rdata <= {24'h000000, ctrl_q};
					s_axi_rresp <= RESP_OKAY;
				end else if (s_axi_araddr[AXI_AW-1:2] == STAT_OFS[AXI_AW-1:2]) begin
					s_axi_rdata <= stat_word;
					s_axi_rresp <= RESP_OKAY;
				end else begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			end
		end
	end

endmodule // ptrs_ctrl

// ===== verification/ptrs_monitor.sv
// Checker on the link between the reset sequencer and the channel.
`timescale 1ns/10ps
module ptrs_monitor
	import ptrs_pkg::*;
#(
	parameter int LANES = LANES_DEF
) (
	input wire logic             clock,
	input wire logic             rst_n,
	input wire logic             multipurpose_pll_hold,
	input wire logic             tx_logic_rst,
	input wire logic             rx_frontend_rst,
	input wire logic             rx_logic_rst,
	input wire logic             powerdown,
	input wire logic             pll_lock_flag,
	input wire logic             busy,
	input wire logic [LANES-1:0] rx_lock_to_data
);
	logic [CNT_W-1:0] hold_cnt_q;
	logic [CNT_W-1:0] pd_cnt_q;

	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// Run lengths of hold and power-down; a long assertion cannot be unrolled, so count it.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt_q <= '0;
			pd_cnt_q   <= '0;
		end else begin
			hold_cnt_q <= multipurpose_pll_hold ? hold_cnt_q + CNT_W'(1) : '0;
			pd_cnt_q   <= powerdown ? pd_cnt_q + CNT_W'(1) : '0;
		end
	end

	// A release is one more held cycle, then the reset is gone.
	sequence s_tx_release;
		tx_logic_rst ##1 !tx_logic_rst;
	endsequence
	sequence s_rx_pulse;
		rx_logic_rst ##1 !rx_logic_rst;
	endsequence

	property p_hold_len;
		$fell(multipurpose_pll_hold) |-> hold_cnt_q >= PLL_HOLD_CYC;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("PLL hold too short");
	property p_hold_all;
		multipurpose_pll_hold |-> tx_logic_rst && rx_frontend_rst && rx_logic_rst;
	endproperty
	a_hold_all: assert property (p_hold_all) else $error("reset released in hold");
	property p_tx_release;
		$rose(pll_lock_flag) && tx_logic_rst && !multipurpose_pll_hold |=> s_tx_release;
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("tx reset timing");
	property p_fe_settle;
		$fell(rx_frontend_rst) |-> !$past(busy, 2) && !$past(busy, 3) && !$past(busy, 4);
	endproperty
	a_fe_settle: assert property (p_fe_settle) else $error("front end released early");
	property p_rx_together;
		$fell(rx_frontend_rst) |-> $fell(rx_logic_rst);
	endproperty
	a_rx_together: assert property (p_rx_together) else $error("rx resets apart");
	property p_pulse_locked;
		$rose(rx_logic_rst) && !rx_frontend_rst |-> rx_lock_to_data != '0;
	endproperty
	a_pulse_locked: assert property (p_pulse_locked) else $error("pulse without lock");
	property p_pulse_len;
		$rose(rx_logic_rst) && !rx_frontend_rst |=> s_rx_pulse;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("logic reset pulse width");
	property p_pd_busy;
		busy |-> !powerdown;
	endproperty
	a_pd_busy: assert property (p_pd_busy) else $error("power-down while busy");
	property p_pd_len;
		$fell(powerdown) |-> pd_cnt_q >= PLL_HOLD_CYC;
	endproperty
	a_pd_len: assert property (p_pd_len) else $error("power-down too short");
endmodule // ptrs_monitor

// ===== verification/ptrs_tb.sv
// Testbench for the reset sequencer and channel model joined by their interface.
`timescale 1ns/10ps
module ptrs_tb
	import ptrs_pkg::*;
;
	localparam int LTD = 8;
	localparam int SHORT = 10;

	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'h0;
	logic [3:0]  sig_ok = 4'hf;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        reconf = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, phy_done, rxlg_q, busy_q;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          n, bad_count, cmp_count, hold_run, hold_len, pulses, busy_rises;

	// Free-running clock at 200 MHz.
	always #2.5 clock = ~clock;

	ptrs_if #(.LANES(4)) ptrs_if_i ();
	ptrs_ctrl #(.LANES(4), .LTD_CYC(LTD)) ptrs_ctrl_i (.clock(clock), .rst_n(rst_n),
		.link(ptrs_if_i.ctrl_mp), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ptrs_xcvr #(.LANES(4), .PLL_LOCK_CYC(SHORT), .CDR_LOCK_CYC(SHORT)) ptrs_xcvr_i (
		.clock(clock), .rst_n(rst_n), .link(ptrs_if_i.xcvr_mp),
		.reconfig_access(reconf), .rx_signal_ok(sig_ok), .phy_done_status(phy_done));
	ptrs_monitor #(.LANES(4)) ptrs_monitor_i (.clock(clock), .rst_n(rst_n),
		.multipurpose_pll_hold(ptrs_if_i.multipurpose_pll_hold),
		.tx_logic_rst(ptrs_if_i.tx_logic_rst), .rx_frontend_rst(ptrs_if_i.rx_frontend_rst),
		.rx_logic_rst(ptrs_if_i.rx_logic_rst), .powerdown(ptrs_if_i.powerdown),
		.pll_lock_flag(ptrs_if_i.pll_lock_flag), .busy(ptrs_if_i.busy),
		.rx_lock_to_data(ptrs_if_i.rx_lock_to_data));

	// Link signals by code: 0 hold, 1 lock, 2 tx, 3 front end, 4 logic, 5 busy, 6 done, 7 pd.
	function automatic logic sig(input int s);
		case (s)
			0: return ptrs_if_i.multipurpose_pll_hold;
			1: return ptrs_if_i.pll_lock_flag;
			2: return ptrs_if_i.tx_logic_rst;
			3: return ptrs_if_i.rx_frontend_rst;
			4: return ptrs_if_i.rx_logic_rst;
			5: return ptrs_if_i.busy;
			6: return phy_done;
			7: return ptrs_if_i.powerdown;
			default: return &ptrs_if_i.rx_lock_to_data;
		endcase
	endfunction

	// Counts edges until a link signal shows the wanted level; only the watchdog ends it.
	task automatic wait_until(input int s, input logic v, output int k);
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (sig(s) !== v);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Address and data go out together and each drops when taken; bready goes out with them and is held until bvalid.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, ed);
		chk(rresp, er);
	endtask

	// Takes every lane's signal away until lock is lost, then gives back the chosen lanes.
	task automatic bounce(input logic [3:0] back);
		sig_ok <= 4'h0;
		wait_until(8, 1'b0, n);
		sig_ok <= back;
	endtask

	task automatic stop_test();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Hold run length, run-phase logic reset pulses and busy pulses seen on the link.
	always @(posedge clock) begin
		rxlg_q <= sig(4);
		busy_q <= sig(5);
		if (sig(4) === 1'b1 && rxlg_q === 1'b0 && sig(3) === 1'b0) pulses <= pulses + 1;
		if (sig(5) === 1'b1 && busy_q === 1'b0) busy_rises <= busy_rises + 1;
		if (sig(0) === 1'b1) begin
			hold_run <= hold_run + 1;
		end else if (hold_run != 0) begin
			hold_len <= hold_run;
			hold_run <= 0;
		end
	end

	// The whole run needs well under a thousand cycles, so this limit only catches a hang.
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		stop_test();
	end

	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk(CTRL_OFS, 32'h0000_0010, RESP_OKAY);
		rd_chk(STAT_OFS, 32'h0000_03c0, RESP_OKAY);
		rd_chk(8'h08, 32'h0000_0000, RESP_SLVERR);
		wr(8'h0c, 32'h0000_00ff, 4'hf, RESP_SLVERR);
		wr(STAT_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
		wr(CTRL_OFS, 32'h0000_00ff, 4'h0, RESP_OKAY);
		rd_chk(CTRL_OFS, 32'h0000_0010, RESP_OKAY);
		wait_until(1, 1'b1, n);
		wait_until(2, 1'b0, n);
		chk(n, 2);
		chk(hold_len >= PLL_HOLD_CYC, 1'b1);
		wait_until(5, 1'b0, n);
		wait_until(3, 1'b0, n);
		chk(n, 4);
		chk({sig(4), ptrs_if_i.rx_lock_to_data}, 32'h0000_0000);
		wait_until(6, 1'b1, n);
		chk(n, 1);
		@(posedge clock);
		chk(sig(6), 1'b0);
		wait_until(8, 1'b1, n);
		bounce(4'hf);
		wait_until(8, 1'b1, n);
		repeat (LTD + 8) @(posedge clock);
		chk(pulses, 0);
		chk(busy_rises, 1);
		reconf <= 1'b1;
		@(posedge clock);
		reconf <= 1'b0;
		wait_until(5, 1'b1, n);
		wait_until(5, 1'b0, n);
		chk(n >= 18 && n <= 22, 1'b1);
		wr(CTRL_OFS, 32'h0000_00f8, 4'h1, RESP_OKAY);
		bounce(4'h7);
		repeat (SHORT + LTD + 8) @(posedge clock);
		chk(pulses, 0);
		sig_ok <= 4'hf;
		wait_until(8, 1'b1, n);
		wait_until(4, 1'b1, n);
		chk(n >= LTD && n <= LTD + 3, 1'b1);
		wait_until(4, 1'b0, n);
		chk(n, 2);
		wr(CTRL_OFS, 32'h0000_00fc, 4'h1, RESP_OKAY);
		bounce(4'hf);
		wait_until(8, 1'b1, n);
		wait_until(4, 1'b1, n);
		chk(n <= 3, 1'b1);
		wr(CTRL_OFS, 32'h0000_0013, 4'h1, RESP_OKAY);
		// The restart reaches the outputs one edge late and the channel flags one edge later.
		repeat (2) @(posedge clock);
		rd_chk(STAT_OFS, 32'h0000_03e0, RESP_OKAY);
		rd_chk(CTRL_OFS, 32'h0000_0012, RESP_OKAY);
		wait_until(3, 1'b0, n);
		chk(hold_len >= PLL_HOLD_CYC, 1'b1);
		chk(busy_rises, 3);
		rst_n <= 1'b0;
		@(posedge clock);
		chk({sig(0), sig(2), sig(3), sig(4), sig(7)}, 5'h1e);
		rst_n <= 1'b1;
		rd_chk(CTRL_OFS, 32'h0000_0010, RESP_OKAY);
		stop_test();
	end
endmodule // ptrs_tb
